/* File: rtl/spm_monitor.sv */
// Overview of operation
// RULE_01: Results readable by register and link bits
// RULE_02: One 24-bit window length shared by channels
// RULE_03: Track largest absolute sample magnitude per window
// RULE_04: Peak is 13 bits, window 24-bit count
// RULE_05: Tracking runs only with control bit 1 set
// RULE_06: Software writes window before enabling tracking
// RULE_07: Enable loads down-counter, decrements every clock
// RULE_08: Keep greater of sample and stored peak
// RULE_09: Seed peak store with current sample magnitude
// RULE_10: At count 1 copy peak to holding register
// RULE_11: Reload counter and reseed after each transfer
// RULE_12: Embedding needs 0x279 bits 1,0 and 0x27A bit 1
// RULE_13: Control-bit sources chosen at 0x559, 0x55A, 0x58F
// RULE_14: Control bits fill from MSB; CS=1 uses MSB
// RULE_15: 25-bit frame, MSB first, five subframes
// RULE_16: Every subframe opens with a start bit
// RULE_17: Receiver reassembles frames from control bits
// RULE_18: Control bits replace tail bits in words
// RULE_19: Holding keeps value; reads have no effect
// RULE_20: Start bit one, peak in low frame bits
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "spm_consts.svh"

module spm_monitor #(
    parameter int NUM_CH = 2
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [11:0] reg_addr_i,
    input wire spm_pkg::spm_byte_t reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output spm_pkg::spm_byte_t reg_rdata_o,
    input wire logic [NUM_CH-1:0][`SPM_SAMPLE_W-1:0] sample_i,
    output logic [NUM_CH-1:0][`SPM_WORD_W-1:0] link_word_o
);
    import spm_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Two's complement negate; the most negative code maps to 0x1000
    function automatic spm_mag_t spm_abs(input logic [12:0] s);
        spm_abs = s[12] ? spm_mag_t'(~s + 13'h0001) : spm_mag_t'(s);
    endfunction : spm_abs

    function automatic spm_mag_t spm_max(input spm_mag_t a,
                                         input spm_mag_t b);
        spm_max = (a > b) ? a : b;
    endfunction : spm_max

    // Start bit high in every subframe, peak in the low 13 data bits
    function automatic spm_frame_t spm_frame(input spm_mag_t p);
        spm_frame = {1'b1, 4'h0, 1'b1, 3'h0, p[12], 1'b1, p[11:8],
                     1'b1, p[7:4], 1'b1, p[3:0]}; // RULE_16 RULE_20
    endfunction : spm_frame

    // ************************************************************
    // Register file
    // ************************************************************
    spm_byte_t ctrl, emb_a, emb_b, src_a, src_b, cs_cfg, rdata;
    spm_byte_t next_ctrl, next_emb_a, next_emb_b, next_src_a;
    spm_byte_t next_src_b, next_cs_cfg, next_rdata;
    logic [`SPM_WIN_W-1:0] win, next_win;
    spm_mag_t hold [NUM_CH];
    logic peak_en, embed_en;
    logic [1:0] cs_num;

    // Write decode and one-cycle read data
    always_comb begin
        next_ctrl = ctrl;
        next_emb_a = emb_a;
        next_emb_b = emb_b;
        next_src_a = src_a;
        next_src_b = src_b;
        next_cs_cfg = cs_cfg;
        next_win = win;
        next_rdata = `SPM_RST_BYTE;
        if (reg_wr_i) begin
            if (reg_addr_i == `SPM_ADDR_CTRL) begin
                next_ctrl = reg_wdata_i; // RULE_05
            end else if (reg_addr_i == `SPM_ADDR_WIN_LO) begin
                next_win[7:0] = reg_wdata_i; // RULE_02
            end else if (reg_addr_i == `SPM_ADDR_WIN_MID) begin
                next_win[15:8] = reg_wdata_i;
            end else if (reg_addr_i == `SPM_ADDR_WIN_HI) begin
                next_win[23:16] = reg_wdata_i;
            end else if (reg_addr_i == `SPM_ADDR_EMB_A) begin
                next_emb_a = reg_wdata_i; // RULE_12
            end else if (reg_addr_i == `SPM_ADDR_EMB_B) begin
                next_emb_b = reg_wdata_i;
            end else if (reg_addr_i == `SPM_ADDR_SRC_A) begin
                next_src_a = reg_wdata_i; // RULE_13
            end else if (reg_addr_i == `SPM_ADDR_SRC_B) begin
                next_src_b = reg_wdata_i;
            end else if (reg_addr_i == `SPM_ADDR_CS) begin
                next_cs_cfg = reg_wdata_i;
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == `SPM_ADDR_CTRL) begin
                next_rdata = ctrl;
            end else if (reg_addr_i == `SPM_ADDR_WIN_LO) begin
                next_rdata = win[7:0];
            end else if (reg_addr_i == `SPM_ADDR_WIN_MID) begin
                next_rdata = win[15:8];
            end else if (reg_addr_i == `SPM_ADDR_WIN_HI) begin
                next_rdata = win[23:16];
            end else if (reg_addr_i == `SPM_ADDR_EMB_A) begin
                next_rdata = emb_a;
            end else if (reg_addr_i == `SPM_ADDR_EMB_B) begin
                next_rdata = emb_b;
            end else if (reg_addr_i == `SPM_ADDR_SRC_A) begin
                next_rdata = src_a;
            end else if (reg_addr_i == `SPM_ADDR_SRC_B) begin
                next_rdata = src_b;
            end else if (reg_addr_i == `SPM_ADDR_CS) begin
                next_rdata = cs_cfg;
            end
            // Holding pairs: low byte then high five bits per channel
            for (int c = 0; c < NUM_CH; c++) begin
                if (reg_addr_i == `SPM_ADDR_HOLD_BASE + 12'(2 * c)) begin
                    next_rdata = hold[c][7:0]; // RULE_01 RULE_19
                end else if (reg_addr_i ==
                             `SPM_ADDR_HOLD_BASE + 12'(2 * c + 1)) begin
                    next_rdata = {3'h0, hold[c][12:8]};
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl <= `SPM_RST_BYTE;
            emb_a <= `SPM_RST_BYTE;
            emb_b <= `SPM_RST_BYTE;
            src_a <= `SPM_RST_BYTE;
            src_b <= `SPM_RST_BYTE;
            cs_cfg <= `SPM_RST_BYTE;
            win <= `SPM_RST_WIN;
            rdata <= `SPM_RST_BYTE;
        end else begin
            ctrl <= next_ctrl;
            emb_a <= next_emb_a;
            emb_b <= next_emb_b;
            src_a <= next_src_a;
            src_b <= next_src_b;
            cs_cfg <= next_cs_cfg;
            win <= next_win;
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_o = rdata;
    assign peak_en = ctrl[`SPM_CTRL_PEAK_EN]; // RULE_05
    assign embed_en = (emb_a[1:0] == 2'b11) &&
                      emb_b[`SPM_EMB_B_BIT]; // RULE_12
    assign cs_num = cs_cfg[`SPM_CS_LSB+1:`SPM_CS_LSB];

    // ************************************************************
    // Window timer and peak trackers
    // ************************************************************
    logic running, next_running, seed, next_seed;
    logic [`SPM_WIN_W-1:0] cnt, next_cnt;
    spm_mag_t peak [NUM_CH];
    spm_mag_t next_peak [NUM_CH];
    spm_mag_t next_hold [NUM_CH];
    spm_mag_t cand [NUM_CH];
    logic xfer;

    // A window of 0 or 1 is treated as one sample so the timer
    // never wraps through zero and stalls reporting for 2^24 clocks.
    // Gated by the enable so a disable never fakes a last transfer.
    assign xfer = running && peak_en && (cnt <= `SPM_WIN_W'(1)); // RULE_10

    // Load and reload behave alike: the sample at hand seeds the store
    // and the counter takes the window, so the first window is no
    // longer than the rest. Reset sets seed; after that it marks a store holding one sample.
    always_comb begin
        next_running = peak_en;
        next_seed = 1'b0;
        next_cnt = cnt;
        for (int c = 0; c < NUM_CH; c++) begin
            cand[c] = spm_max(peak[c], spm_abs(sample_i[c]));
            next_peak[c] = peak[c];
            next_hold[c] = hold[c]; // RULE_19
        end
        if (peak_en && (!running || xfer)) begin
            next_cnt = win; // RULE_07 RULE_11
            next_seed = 1'b1;
            for (int c = 0; c < NUM_CH; c++) begin
                next_peak[c] = spm_abs(sample_i[c]); // RULE_09 RULE_03
                if (xfer) begin
                    next_hold[c] = peak[c]; // RULE_10 RULE_04
                end
            end
        end else if (peak_en) begin
            next_cnt = cnt - `SPM_WIN_W'(1); // RULE_07
            for (int c = 0; c < NUM_CH; c++) begin
                next_peak[c] = cand[c]; // RULE_08
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            running <= 1'b0;
            seed <= 1'b1;
            cnt <= `SPM_RST_WIN;
            for (int c = 0; c < NUM_CH; c++) begin
                peak[c] <= '0;
                hold[c] <= '0;
            end
        end else begin
            running <= next_running;
            seed <= next_seed;
            cnt <= next_cnt;
            for (int c = 0; c < NUM_CH; c++) begin
                peak[c] <= next_peak[c];
                hold[c] <= next_hold[c];
            end
        end
    end

    // ************************************************************
    // Frame serializer and link word assembly
    // ************************************************************
    spm_ser_e ser_st [NUM_CH];
    spm_ser_e next_ser_st [NUM_CH];
    spm_frame_t shreg [NUM_CH];
    spm_frame_t next_shreg [NUM_CH];
    logic [4:0] bitcnt [NUM_CH];
    logic [4:0] next_bitcnt [NUM_CH];
    logic [NUM_CH-1:0] pend, next_pend;
    logic [NUM_CH-1:0][`SPM_WORD_W-1:0] next_word;
    logic [2:0] srcs [3];
    logic mon_bit;

    assign srcs[0] = src_a[2:0];
    assign srcs[1] = src_a[6:4];
    assign srcs[2] = src_b[2:0];

    // A new peak arriving mid-frame waits; the frame in flight is
    // never cut, so the receiver only ever sees whole frames.
    always_comb begin
        mon_bit = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            next_ser_st[c] = ser_st[c];
            next_shreg[c] = shreg[c];
            next_bitcnt[c] = bitcnt[c];
            next_pend[c] = pend[c];
            case (ser_st[c])
                SPM_SER_IDLE: begin
                    if (pend[c]) begin
                        next_ser_st[c] = SPM_SER_SEND;
                        next_shreg[c] = spm_frame(hold[c]); // RULE_15
                        next_bitcnt[c] = 5'h00;
                        next_pend[c] = 1'b0;
                    end
                end
                SPM_SER_SEND: begin
                    next_shreg[c] = {shreg[c][23:0], 1'b0}; // RULE_15
                    next_bitcnt[c] = bitcnt[c] + 5'h01;
                    if (bitcnt[c] == `SPM_FRAME_LAST) begin
                        next_ser_st[c] = SPM_SER_IDLE;
                    end
                end
                default: begin
                    next_ser_st[c] = SPM_SER_IDLE;
                end
            endcase
            // Transfer sets the request even while it is being taken
            if (xfer) begin
                next_pend[c] = 1'b1;
            end
            mon_bit = (ser_st[c] == SPM_SER_SEND) && shreg[c][24];
            next_word[c] = {sample_i[c], 3'h0}; // RULE_18
            for (int j = 0; j < `SPM_CTRL_SLOTS; j++) begin
                if (embed_en && (2'(j) < cs_num) &&
                    (srcs[j] == `SPM_SRC_MON)) begin
                    next_word[c][2-j] = mon_bit; // RULE_14 RULE_01
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pend <= '0;
            link_word_o <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                ser_st[c] <= SPM_SER_IDLE;
                shreg[c] <= '0;
                bitcnt[c] <= 5'h00;
            end
        end else begin
            pend <= next_pend;
            link_word_o <= next_word;
            for (int c = 0; c < NUM_CH; c++) begin
                ser_st[c] <= next_ser_st[c];
                shreg[c] <= next_shreg[c];
                bitcnt[c] <= next_bitcnt[c];
            end
        end
    end

    // ************************************************************
    // Assertions (channel 0)
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_hold_read;
        reg_rd_i && (reg_addr_i == `SPM_ADDR_HOLD_BASE);
    endsequence
    sequence s_window_end;
        running && peak_en && (cnt <= `SPM_WIN_W'(1));
    endsequence

    property p_hold_read;
        s_hold_read |=> (reg_rdata_o == $past(hold[0][7:0]));
    endproperty
    a_hold_read: assert property (p_hold_read) // RULE_01
        else $error("holding readback wrong");

    property p_idle_when_off;
        !peak_en ##1 !peak_en |-> !running && $stable(hold[0]);
    endproperty
    a_idle_when_off: assert property (p_idle_when_off) // RULE_05
        else $error("tracking while disabled");

    property p_load;
        peak_en && !running |=> running && (cnt == $past(win));
    endproperty
    a_load: assert property (p_load) // RULE_07
        else $error("window not loaded on enable");

    property p_dec;
        running && peak_en && (cnt > `SPM_WIN_W'(1))
            |=> (cnt == $past(cnt) - `SPM_WIN_W'(1));
    endproperty
    a_dec: assert property (p_dec) // RULE_07
        else $error("timer did not decrement");

    property p_max;
        running && peak_en && (cnt > `SPM_WIN_W'(1))
            |=> (peak[0] >= $past(peak[0])) &&
                (peak[0] >= spm_abs($past(sample_i[0])));
    endproperty
    a_max: assert property (p_max) // RULE_08
        else $error("peak store lost maximum");

    property p_seed;
        peak_en && (!running || xfer)
            |=> seed && (peak[0] == spm_abs($past(sample_i[0])));
    endproperty
    a_seed: assert property (p_seed) // RULE_09
        else $error("peak store not seeded");

    property p_xfer;
        s_window_end |=> (hold[0] == $past(peak[0])) &&
                         (cnt == $past(win)) && seed;
    endproperty
    a_xfer: assert property (p_xfer) // RULE_10
        else $error("window end transfer wrong");

    property p_hold_keep;
        !xfer |=> $stable(hold[0]);
    endproperty
    a_hold_keep: assert property (p_hold_keep) // RULE_19
        else $error("holding changed mid window");

    property p_start_bit;
        (ser_st[0] == SPM_SER_SEND) && (bitcnt[0] % 5'd5 == 5'd0)
            |-> shreg[0][24];
    endproperty
    a_start_bit: assert property (p_start_bit) // RULE_16
        else $error("missing subframe start bit");

    property p_no_embed;
        !embed_en |=> (link_word_o[0][2:0] == 3'h0) &&
            (link_word_o[0][15:3] == $past(sample_i[0]));
    endproperty
    a_no_embed: assert property (p_no_embed) // RULE_12
        else $error("control bits without embedding");

    property p_frame_len;
        (ser_st[0] == SPM_SER_IDLE) ##1 (ser_st[0] == SPM_SER_SEND)
            |-> ##24 (ser_st[0] == SPM_SER_SEND) ##1
                (ser_st[0] == SPM_SER_IDLE);
    endproperty
    a_frame_len: assert property (p_frame_len) // RULE_15
        else $error("frame not 25 bits long");

endmodule : spm_monitor
`default_nettype wire

/* File: rtl/spm_consts.svh */
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SPM_ADDR_CTRL 12'h270
`define SPM_ADDR_WIN_LO 12'h271
`define SPM_ADDR_WIN_MID 12'h272
`define SPM_ADDR_WIN_HI 12'h273
`define SPM_ADDR_HOLD_BASE 12'h274
`define SPM_ADDR_EMB_A 12'h279
`define SPM_ADDR_EMB_B 12'h27A
`define SPM_ADDR_SRC_A 12'h559
`define SPM_ADDR_SRC_B 12'h55A
`define SPM_ADDR_CS 12'h58F

// ****************************************************************
// Field positions, codes and widths
// ****************************************************************
`define SPM_CTRL_PEAK_EN 1
`define SPM_EMB_B_BIT 1
`define SPM_SRC_MON 3'h5
`define SPM_CS_LSB 6
`define SPM_WIN_W 24
`define SPM_MAG_W 13
`define SPM_SAMPLE_W 13
`define SPM_WORD_W 16
`define SPM_CTRL_SLOTS 3
`define SPM_FRAME_W 25
`define SPM_SUB_W 5
`define SPM_FRAME_LAST 5'h18

// ****************************************************************
// Reset values
// ****************************************************************
`define SPM_RST_BYTE 8'h00
`define SPM_RST_WIN 24'h000000

`endif

/* File: rtl/spm_pkg.sv */
`include "spm_consts.svh"

package spm_pkg;
    typedef logic [7:0] spm_byte_t;
    typedef logic [`SPM_MAG_W-1:0] spm_mag_t;
    typedef logic [`SPM_FRAME_W-1:0] spm_frame_t;
    typedef enum logic [0:0] {
        SPM_SER_IDLE = 1'b0,
        SPM_SER_SEND = 1'b1
    } spm_ser_e;
endpackage : spm_pkg

/* File: verification/spm_link_rx.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************************
// Link receiver model
// ********************************
module spm_link_rx (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] link_word_i,
    input wire logic [1:0] slot_i,
    output spm_pkg::spm_mag_t peak_o,
    output logic done_o,
    output logic err_o
);
    import spm_pkg::*;
    logic busy;
    logic [4:0] cnt;
    logic [23:0] sh;
    logic bit_in;
    logic [24:0] frm;
    // Slot j rides in word bit 2-j, so slot 0 is the top tail bit
    assign bit_in = link_word_i[2'd2 - slot_i];
    assign frm = {sh, bit_in};
    // Idle bits are 0; a 1 opens a frame of 25 bits, MSB first
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy <= 1'b0;
            cnt <= 5'h00;
            sh <= 24'h000000;
            peak_o <= 13'h0000;
            done_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            sh <= frm[23:0];
            if (!busy) begin
                busy <= bit_in;
                cnt <= 5'h01;
            end else if (cnt == 5'h18) begin
                busy <= 1'b0;
                done_o <= 1'b1;
                // Pad bits are skipped; peak sits in the low bits
                peak_o <= {frm[15], frm[13:10], frm[8:5], frm[3:0]};
                err_o <= ~&{frm[24], frm[19], frm[14], frm[9], frm[4]}
                    | (|{frm[23:20], frm[18:16]});
            end else begin
                cnt <= cnt + 5'h01;
            end
        end
    end
endmodule : spm_link_rx
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spm_consts.svh"
module tb_top;
    import spm_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    spm_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    spm_byte_t reg_rdata;
    logic [1:0][12:0] sample = '0;
    logic [1:0][15:0] link_word;
    logic [1:0] rx_slot = 2'h0;
    wire spm_mag_t rx_peak [2];
    wire [1:0] rx_done;
    wire [1:0] rx_err;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int n_frames = 0;
    int quiet;
    logic m_en;
    logic m_run;
    logic [23:0] m_cnt;
    logic [23:0] m_win;
    spm_mag_t m_peak [2];
    spm_mag_t m_hold [2];
    spm_mag_t hold_pre [2];
    logic [1:0][12:0] smp_prev;
    logic [2:0] mask;
    spm_byte_t r279, r27a, r559, r55a, r58f;
    spm_byte_t e279 [5] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h01};
    spm_byte_t e559 [5] = '{8'h05, 8'h50, 8'h00, 8'h00, 8'h05};
    spm_byte_t e55a [5] = '{8'h00, 8'h00, 8'h05, 8'h05, 8'h00};
    spm_byte_t e58f [5] = '{8'h40, 8'hC0, 8'hC0, 8'h80, 8'h40};
    logic [1:0] eslot [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};

    // Free-running sample clock
    always #12.5 sys_clk = ~sys_clk;

    spm_monitor #(.NUM_CH(2)) spm_monitor_inst (.sys_clk_i(sys_clk),
        .reset_n_i(reset_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .sample_i(sample), .link_word_o(link_word));
    for (genvar c = 0; c < 2; c++) begin : g_rx
        spm_link_rx spm_link_rx_inst (.sys_clk_i(sys_clk),
            .reset_n_i(reset_n), .link_word_i(link_word[c]),
            .slot_i(rx_slot), .peak_o(rx_peak[c]), .done_o(rx_done[c]),
            .err_o(rx_err[c]));
    end

    // ********************************
    // Expectation helpers
    // ********************************
    function automatic spm_mag_t f_mag(input logic [12:0] s);
        return s[12] ? spm_mag_t'(-s) : spm_mag_t'(s);
    endfunction : f_mag
    function automatic logic [2:0] f_mask();
        logic emb;
        emb = (r279[1:0] == 2'b11) && r27a[1];
        return {emb && r58f[7:6] > 2'd0 && r559[2:0] == `SPM_SRC_MON,
            emb && r58f[7:6] > 2'd1 && r559[6:4] == `SPM_SRC_MON,
            emb && r58f[7:6] > 2'd2 && r55a[2:0] == `SPM_SRC_MON};
    endfunction : f_mask
    // Full-scale extremes come often, the most negative code included
    function automatic logic [12:0] f_smp();
        case ($urandom_range(7, 0))
            0: return 13'h1000;
            1: return 13'h0FFF;
            2: return 13'h1FFF;
            default: return 13'($urandom);
        endcase
    endfunction : f_smp
    task automatic cmp_reg(input spm_byte_t got, input spm_byte_t exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_reg
    task automatic cmp_peak(input spm_mag_t got, input spm_mag_t exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_peak
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic final_report();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // ********************************
    // Reference model and link checks
    // ********************************
    // Reads only values settled before the edge, so order never matters
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {m_en, m_run, m_cnt, m_win, smp_prev} = '0;
            {r279, r27a, r559, r55a, r58f} = '0;
            quiet = 0;
            for (int c = 0; c < 2; c++) begin
                m_peak[c] = '0;
                m_hold[c] = '0;
                hold_pre[c] = '0;
            end
        end else begin
            mask = f_mask();
            for (int c = 0; c < 2; c++) begin
                hold_pre[c] = m_hold[c];
                if (quiet > 2) cmp_word({link_word[c][15:3], link_word[c][2:0] & ~mask}, {smp_prev[c], 3'b000});
                if (rx_done[c]) begin
                    n_frames++;
                    cmp_peak(rx_peak[c], m_hold[c]);
                    cmp_reg({7'h00, rx_err[c]}, 8'h00);
                end
                smp_prev[c] = sample[c];
            end
            if (m_en && m_run && m_cnt > 24'd1) begin
                m_cnt--;
                for (int c = 0; c < 2; c++) begin
                    if (f_mag(sample[c]) > m_peak[c]) m_peak[c] = f_mag(sample[c]);
                end
            end else begin
                for (int c = 0; c < 2; c++) begin
                    if (m_en && m_run) m_hold[c] = m_peak[c];
                    m_peak[c] = f_mag(sample[c]);
                end
                m_run = m_en;
                m_cnt = (m_win == 24'd0) ? 24'd1 : m_win;
            end
            quiet++;
            if (reg_wr) begin
                quiet = 0;
                case (reg_addr)
                    `SPM_ADDR_CTRL: m_en = reg_wdata[1];
                    `SPM_ADDR_WIN_LO: m_win[7:0] = reg_wdata;
                    `SPM_ADDR_WIN_MID: m_win[15:8] = reg_wdata;
                    `SPM_ADDR_WIN_HI: m_win[23:16] = reg_wdata;
                    `SPM_ADDR_EMB_A: r279 = reg_wdata;
                    `SPM_ADDR_EMB_B: r27a = reg_wdata;
                    `SPM_ADDR_SRC_A: r559 = reg_wdata;
                    `SPM_ADDR_SRC_B: r55a = reg_wdata;
                    `SPM_ADDR_CS: r58f = reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // ********************************
    // Stimulus
    // ********************************
    // New samples every edge; the timeout ends a hang
    always @(posedge sys_clk) begin
        sample[0] <= f_smp();
        sample[1] <= f_smp();
        cycles++;
        if (cycles >= 6000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic run(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : run
    task automatic reg_write(input logic [11:0] a, input spm_byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [11:0] a, output spm_byte_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read
    task automatic set_win(input logic [23:0] w);
        reg_write(`SPM_ADDR_WIN_LO, w[7:0]);
        reg_write(`SPM_ADDR_WIN_MID, w[15:8]);
        reg_write(`SPM_ADDR_WIN_HI, w[23:16]);
    endtask : set_win
    // Byte halves are read apart, each against its own moment
    task automatic rd_hold(input int c);
        spm_byte_t d;
        reg_read(`SPM_ADDR_HOLD_BASE + 12'(2 * c), d);
        cmp_reg(d, hold_pre[c][7:0]);
        reg_read(`SPM_ADDR_HOLD_BASE + 12'(2 * c + 1), d);
        cmp_reg(d, {3'b000, hold_pre[c][12:8]});
    endtask : rd_hold

    initial begin
        spm_byte_t d;
        int f0;
        static int wins [4] = '{3, 1, 0, 7};
        void'($urandom(8));
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int a = 'h270; a <= 'h277; a++) begin
            reg_read(12'(a), d);
            cmp_reg(d, 8'h00);
        end
        reg_read(12'h300, d);
        cmp_reg(d, 8'h00);
        set_win(24'hABCDEF);
        reg_read(`SPM_ADDR_WIN_LO, d);
        cmp_reg(d, 8'hEF);
        reg_read(`SPM_ADDR_WIN_HI, d);
        cmp_reg(d, 8'hAB);
        @(posedge sys_clk);
        #1 cmp_reg(reg_rdata, 8'h00);
        set_win(24'h000003);
        reg_write(`SPM_ADDR_CTRL, 8'h02);
        reg_read(`SPM_ADDR_CTRL, d);
        cmp_reg(d, 8'h02);
        foreach (wins[w]) begin
            set_win(24'(wins[w]));
            for (int i = 0; i < 20; i++) begin
                run($urandom_range(5, 0));
                rd_hold(i % 2);
            end
        end
        reg_write(`SPM_ADDR_CTRL, 8'h00);
        run(50);
        rd_hold(0);
        rd_hold(1);
        run(30);
        rd_hold(0);
        set_win(24'd40);
        for (int k = 0; k < 5; k++) begin
            reg_write(`SPM_ADDR_CTRL, 8'h00);
            run(40);
            f0 = n_frames;
            reg_write(`SPM_ADDR_EMB_A, e279[k]);
            reg_write(`SPM_ADDR_EMB_B, 8'h02);
            reg_write(`SPM_ADDR_SRC_A, e559[k]);
            reg_write(`SPM_ADDR_SRC_B, e55a[k]);
            reg_write(`SPM_ADDR_CS, e58f[k]);
            rx_slot <= eslot[k];
            reg_write(`SPM_ADDR_CTRL, 8'h02);
            for (int i = 0; i < 6; i++) begin
                run(30);
                rd_hold(i % 2);
            end
            cmp_reg({7'h00, n_frames > f0}, {7'h00, k < 3});
        end
        final_report();
    end
endmodule : tb_top
`default_nettype wire
